// *** mrs_pkg.sv ***
/*
 Package for the measure/read command sequencer: command and function
 encodings plus the packed structs that carry queries and readings.
 Assumes a single clock domain and a parsed query arriving as one pulse.
*/
package mrs_pkg;

   localparam int FUNC_W    = 4;
   localparam int READING_W = 32;

   typedef enum logic [3:0] {
      FN_DC_VOLTAGE                 = 4'h0,
      FN_DC_CURRENT                 = 4'h1,
      FN_AC_VOLTAGE                 = 4'h2,
      FN_AC_CURRENT                 = 4'h3,
      FN_TWO_WIRE_FUNCTION_A        = 4'h4,
      FN_FOUR_WIRE_TWO_WIRE_FUNCTION_A       = 4'h5,
      FN_TEMPERATURE                = 4'h6,
      FN_FREQUENCY                  = 4'h7,
      FN_FREQUENCY_VOLTAGE          = 4'h8,
      FN_FREQUENCY_CURRENT          = 4'h9
   } func_t;

   localparam logic [3:0] FUNC_LAST     = 4'h9;
   localparam func_t      FUNC_RESET    = FN_DC_VOLTAGE;
   localparam logic [1:0] TRIG_LAYERS   = 2'h3;
   localparam logic [7:0] TRIG_COUNT_ONE = 8'h01;

   typedef enum logic [1:0] {
      CMD_READ    = 2'h0,
      CMD_MEASURE = 2'h1
   } cmd_t;

   typedef struct packed {
      cmd_t        cmd;
      logic        has_func;
      logic [3:0]  func;
   } query_t;

   typedef struct packed {
      logic        continuous;
      logic [3:0]  func;
      logic [7:0]  arm_count;
      logic [7:0]  scan_count;
      logic [7:0]  meas_count;
   } config_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] value;
   } reading_t;

endpackage : mrs_pkg

// *** mrs_fetch.sv ***
/*
 Fetch step: asks the front end for one fresh conversion and latches its
 reading. Assumes the front end answers each request with one done pulse.
*/
module mrs_fetch #(
   parameter int READING_W = 32
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_nrst,
   input  wire logic                 i_start,
   input  wire logic                 i_conv_done,
   input  wire logic [READING_W-1:0] i_conv_value,
   output logic                      o_conv_start,
   output logic                      o_done,
   output logic [READING_W-1:0]      o_value
);

   logic                 busy_reg;
   logic                 busy_next;
   logic                 done_reg;
   logic                 done_next;
   logic [READING_W-1:0] value_reg;
   logic [READING_W-1:0] value_next;

   always_comb begin
      busy_next  = busy_reg;
      value_next = value_reg;
      done_next  = busy_reg && i_conv_done;
      if (i_start) begin
         busy_next = 1'b1;
      end else if (busy_reg && i_conv_done) begin
         busy_next  = 1'b0;
         value_next = i_conv_value; // see RULE_06
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
         value_reg <= '0;
      end else begin
         busy_reg  <= busy_next;
         done_reg  <= done_next;
         value_reg <= value_next;
      end
   end

   // Exactly one conversion per fetch; a stale value is returned only if i_start comes while busy_reg is set.
   assign o_conv_start = i_start; // see RULE_07
   // Done trails the conversion by one cycle so that it meets the latched value.
   assign o_done       = done_reg; // see RULE_06
   assign o_value      = value_reg;

endmodule : mrs_fetch

// *** measure_read_sequencer.sv ***
/*
 Sequencer that expands the read and measure queries into abort,
 configure, initiate and fetch steps. Assumes a parsed query pulse from
 the bus front end and a conversion engine answering with done pulses.
*/
// Behaviour
// RULE_01: Read query runs abort, then initiate, then fetch returning the reading.
// RULE_02: Abort idles device if continuous off, else restarts trigger model.
// RULE_03: Initiate takes an idle device out of idle.
// RULE_04: With continuous on, initiate raises initiate-ignored error, nothing else.
// RULE_05: Initiate-ignored error does not cancel the following fetch.
// RULE_06: Fetch returns a freshly acquired reading, never an old one.
// RULE_07: In one-shot mode each read query causes exactly one conversion.
// RULE_08: Measure without function keyword uses the currently selected function.
// RULE_09: Measure runs abort, configure function, then full read sequence.
// RULE_10: Measure accepts the ten listed function keywords including three frequencies.
// RULE_11: Configure inside measure puts device in one-shot mode.
// RULE_12: Configure selects function, continuous off, trigger counts one, idle.
// RULE_13: Host addresses device to talk only after a query, takes one reading.
module measure_read_sequencer #(
   parameter int READING_W = 32
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_nrst,
   input  wire logic                  i_query_valid,
   input  wire mrs_pkg::query_t       i_query,
   input  wire logic                  i_cont_set,
   input  wire logic                  i_cont_value,
   input  wire logic                  i_conv_done,
   input  wire logic [READING_W-1:0]  i_conv_value,
   output logic                       o_query_ready,
   output logic                       o_conv_start,
   output logic                       o_trigger_restart,
   output logic                       o_idle,
   output logic                       o_init_ignored,
   output logic                       o_bad_function,
   output mrs_pkg::config_t           o_config,
   output mrs_pkg::reading_t          o_reading
);

   typedef enum logic [2:0] {
      ST_WAIT,
      ST_ABORT_M,
      ST_CONFIGURE,
      ST_ABORT_R,
      ST_INITIATE,
      ST_FETCH,
      ST_FETCH_WAIT
   } state_t;

   state_t            state_reg;
   state_t            state_next;
   mrs_pkg::config_t  cfg_reg;
   mrs_pkg::config_t  cfg_next;
   logic              idle_reg;
   logic              idle_next;
   logic [3:0]        func_reg;
   logic [3:0]        func_next;
   logic              restart_reg;
   logic              restart_next;
   logic              ignored_reg;
   logic              ignored_next;
   logic              bad_reg;
   logic              bad_next;
   mrs_pkg::reading_t reading_reg;
   mrs_pkg::reading_t reading_next;
   logic              fetch_start;
   logic              fetch_done;
   logic [READING_W-1:0] fetch_value;

   mrs_fetch #(.READING_W(READING_W)) u_fetch (
      .i_clock      (i_clock),
      .i_nrst       (i_nrst),
      .i_start      (fetch_start),
      .i_conv_done  (i_conv_done),
      .i_conv_value (i_conv_value),
      .o_conv_start (o_conv_start),
      .o_done       (fetch_done),
      .o_value      (fetch_value)
   );

   always_comb begin
      state_next   = state_reg;
      cfg_next     = cfg_reg;
      idle_next    = idle_reg;
      func_next    = func_reg;
      restart_next = 1'b0;
      ignored_next = 1'b0;
      bad_next     = 1'b0;
      reading_next = reading_reg;
      reading_next.valid = 1'b0;
      fetch_start  = 1'b0;
      case (state_reg)
         ST_WAIT: begin
            if (i_cont_set) begin
               cfg_next.continuous = i_cont_value;
            end
            if (i_query_valid) begin
               if (i_query.cmd == mrs_pkg::CMD_MEASURE) begin
                  // Missing keyword falls back to the function in force.
                  func_next = i_query.has_func ? i_query.func : cfg_reg.func; // see RULE_08
                  if (i_query.has_func && i_query.func > mrs_pkg::FUNC_LAST) begin
                     bad_next = 1'b1; // see RULE_10
                  end else begin
                     state_next = ST_ABORT_M; // see RULE_09
                  end
               end else begin
                  state_next = ST_ABORT_R; // see RULE_01
               end
            end
         end
         ST_ABORT_M, ST_ABORT_R: begin
            if (cfg_reg.continuous) begin
               restart_next = 1'b1; // see RULE_02
            end else begin
               idle_next = 1'b1; // see RULE_02
            end
            state_next = (state_reg == ST_ABORT_M) ? ST_CONFIGURE : ST_INITIATE;
         end
         ST_CONFIGURE: begin
            cfg_next.func       = func_reg; // see RULE_12
            cfg_next.continuous = 1'b0; // see RULE_11
            cfg_next.arm_count  = mrs_pkg::TRIG_COUNT_ONE;
            cfg_next.scan_count = mrs_pkg::TRIG_COUNT_ONE;
            cfg_next.meas_count = mrs_pkg::TRIG_COUNT_ONE;
            idle_next           = 1'b1;
            state_next          = ST_ABORT_R; // see RULE_09
         end
         ST_INITIATE: begin
            if (cfg_reg.continuous) begin
               ignored_next = 1'b1; // see RULE_04
            end else if (idle_reg) begin
               idle_next = 1'b0; // see RULE_03
            end
            // The error leaves the fetch in place.
            state_next = ST_FETCH; // see RULE_05
         end
         ST_FETCH: begin
            fetch_start = 1'b1; // see RULE_07
            state_next  = ST_FETCH_WAIT;
         end
         ST_FETCH_WAIT: begin
            if (fetch_done) begin
               reading_next.valid = 1'b1; // see RULE_06
               reading_next.value = fetch_value;
               if (!cfg_reg.continuous) begin
                  idle_next = 1'b1;
               end
               state_next = ST_WAIT;
            end
         end
         default: begin
            state_next = ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg   <= ST_WAIT;
         cfg_reg     <= '{continuous: 1'b0, func: mrs_pkg::FUNC_RESET,
                          arm_count: mrs_pkg::TRIG_COUNT_ONE,
                          scan_count: mrs_pkg::TRIG_COUNT_ONE,
                          meas_count: mrs_pkg::TRIG_COUNT_ONE};
         idle_reg    <= 1'b1;
         func_reg    <= mrs_pkg::FUNC_RESET;
         restart_reg <= 1'b0;
         ignored_reg <= 1'b0;
         bad_reg     <= 1'b0;
         reading_reg <= '0;
      end else begin
         state_reg   <= state_next;
         cfg_reg     <= cfg_next;
         idle_reg    <= idle_next;
         func_reg    <= func_next;
         restart_reg <= restart_next;
         ignored_reg <= ignored_next;
         bad_reg     <= bad_next;
         reading_reg <= reading_next;
      end
   end

   assign o_query_ready     = (state_reg == ST_WAIT);
   assign o_trigger_restart = restart_reg;
   assign o_idle            = idle_reg;
   assign o_init_ignored    = ignored_reg;
   assign o_bad_function    = bad_reg;
   assign o_config          = cfg_reg;
   assign o_reading         = reading_reg;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   a_read_order: assert property ( // see RULE_01
      state_reg == ST_ABORT_R |=> state_reg == ST_INITIATE ##1 state_reg == ST_FETCH)
      else $error("Read steps out of order.");
   a_abort_idle: assert property ( // see RULE_02
      state_reg == ST_ABORT_R && !cfg_reg.continuous |=> idle_reg && !restart_reg)
      else $error("Abort did not idle.");
   a_abort_restart: assert property ( // see RULE_02
      state_reg == ST_ABORT_R && cfg_reg.continuous |=> restart_reg)
      else $error("Abort did not restart trigger model.");
   a_init_leave: assert property ( // see RULE_03
      state_reg == ST_INITIATE && !cfg_reg.continuous |=> !idle_reg)
      else $error("Initiate left device idle.");
   a_init_ignored: assert property ( // see RULE_04
      state_reg == ST_INITIATE && cfg_reg.continuous |=> ignored_reg && $stable(idle_reg))
      else $error("Initiate not ignored.");
   a_error_fetch: assert property ( // see RULE_05
      ignored_reg |-> state_reg == ST_FETCH && o_conv_start)
      else $error("Fetch cancelled by error.");
   a_fresh_value: assert property ( // see RULE_06
      state_reg == ST_FETCH_WAIT && i_conv_done |=> ##1
         reading_reg.valid && reading_reg.value == $past(i_conv_value, 2))
      else $error("Reading not fresh.");
   a_one_conv: assert property ( // see RULE_07
      o_conv_start |=> !o_conv_start)
      else $error("More than one conversion.");
   a_default_func: assert property ( // see RULE_08
      o_query_ready && i_query_valid && i_query.cmd == mrs_pkg::CMD_MEASURE && !i_query.has_func
      |=> func_reg == $past(cfg_reg.func))
      else $error("Default function not used.");
   a_meas_order: assert property ( // see RULE_09
      state_reg == ST_ABORT_M |=> state_reg == ST_CONFIGURE ##1 state_reg == ST_ABORT_R)
      else $error("Measure steps out of order.");
   a_bad_func: assert property ( // see RULE_10
      o_query_ready && i_query_valid && i_query.cmd == mrs_pkg::CMD_MEASURE
      && i_query.has_func && i_query.func > mrs_pkg::FUNC_LAST |=> bad_reg && state_reg == ST_WAIT)
      else $error("Unknown function accepted.");
   a_oneshot: assert property ( // see RULE_11
      state_reg == ST_CONFIGURE |=> !cfg_reg.continuous)
      else $error("Configure left continuous on.");
   a_config_state: assert property ( // see RULE_12
      state_reg == ST_CONFIGURE |=> cfg_reg.func == $past(func_reg) && idle_reg
      && cfg_reg.arm_count == mrs_pkg::TRIG_COUNT_ONE && cfg_reg.meas_count == mrs_pkg::TRIG_COUNT_ONE)
      else $error("Configure state wrong.");

   c_read: cover property (state_reg == ST_ABORT_R ##[1:50] reading_reg.valid);
   c_measure: cover property (state_reg == ST_CONFIGURE ##[1:50] reading_reg.valid);
   c_ignored: cover property (ignored_reg ##[1:50] reading_reg.valid);
   c_restart: cover property (restart_reg);

endmodule : measure_read_sequencer

// *** mrs_conv_model.sv ***
/*
 Behavioural conversion engine: answers each start request with one done
 pulse after a chosen number of cycles and a fresh value every time.
 Assumes one clock, active low asynchronous reset, one request at a time.
*/
module mrs_conv_model (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic        i_start,
   input  wire logic [2:0]  i_delay,
   output logic             o_done,
   output logic [31:0]      o_value
);
   timeunit 1ns;
   timeprecision 1ns;

   logic        busy;
   logic [2:0]  wait_cnt;
   logic [31:0] seq;

   // Outside the done pulse the value is inverted, so a stale latch shows up.
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         busy     <= 1'b0;
         wait_cnt <= 3'h0;
         seq      <= 32'h0000_0000;
         o_done   <= 1'b0;
         o_value  <= 32'h0000_0000;
      end else begin
         o_done <= 1'b0;
         if (o_done) o_value <= ~o_value;
         if (i_start) begin
            busy     <= 1'b1;
            wait_cnt <= i_delay;
         end else if (busy && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
         end else if (busy) begin
            busy    <= 1'b0;
            o_done  <= 1'b1;
            o_value <= 32'hA500_0000 + seq;
            seq     <= seq + 32'h0000_0001;
         end
      end
   end
endmodule : mrs_conv_model

// *** measure_read_sequencer_tb_top.sv ***
/*
 Self-checking bench for the measure/read sequencer with a conversion model.
 Assumes the sequencer answers each accepted query with one conversion and one reading.
*/
module measure_read_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic              query_valid = 1'b0;
   logic              cont_set = 1'b0;
   logic              cont_value = 1'b0;
   mrs_pkg::query_t   query = '0;
   logic [2:0]        delay = 3'h0;
   logic              conv_start, conv_done, query_ready, restart, idle, ignored, bad_func;
   logic [31:0]       conv_value;
   mrs_pkg::config_t  cfg;
   mrs_pkg::reading_t reading;
   int                fails = 0, total_checks = 0, cycles = 0, n_conv = 0;
   logic              exp_cont = 1'b0;
   logic [3:0]        exp_func = 4'h0;

   always #5 clock = ~clock;

   measure_read_sequencer i_measure_read_sequencer (
      .i_clock(clock), .i_nrst(nrst), .i_query_valid(query_valid), .i_query(query),
      .i_cont_set(cont_set), .i_cont_value(cont_value), .i_conv_done(conv_done),
      .i_conv_value(conv_value), .o_query_ready(query_ready), .o_conv_start(conv_start),
      .o_trigger_restart(restart), .o_idle(idle), .o_init_ignored(ignored),
      .o_bad_function(bad_func), .o_config(cfg), .o_reading(reading));

   mrs_conv_model i_mrs_conv_model (
      .i_clock(clock), .i_nrst(nrst), .i_start(conv_start), .i_delay(delay),
      .o_done(conv_done), .o_value(conv_value));

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task results;
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // A hung sequencer would otherwise stall the run forever.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         results();
      end
   end

   task set_cont(input logic v);
      cont_set = 1'b1;
      cont_value = v;
      @(negedge clock);
      cont_set = 1'b0;
      exp_cont = v;
   endtask : set_cont

   // One query, then wait for its single reading, or for the bad-function flag on a rejected query, before the next one.
   task run(input logic [1:0] cmd, input logic hf, input logic [3:0] fn);
      int   k, starts, ign, rs, busy;
      logic done;
      logic pc;
      starts = 0; ign = 0; rs = 0; busy = 0; done = 1'b0;
      pc = exp_cont;
      chk("query_ready", 1, query_ready);
      query_valid = 1'b1;
      query.cmd = mrs_pkg::cmd_t'(cmd);
      query.has_func = hf;
      query.func = fn;
      delay = 3'($urandom_range(7));
      @(negedge clock);
      query_valid = 1'b0;
      for (k = 0; k < 100 && !done; k++) begin
         starts += int'(conv_start);
         ign |= int'(ignored);
         rs |= int'(restart);
         busy |= int'(!idle);
         if (bad_func === 1'b1 || reading.valid === 1'b1) done = 1'b1;
         else @(negedge clock);
      end
      if (cmd == 2'h1 && hf && fn > 4'h9) begin
         chk("bad_function", 1, bad_func);
         chk("conv_starts", 0, starts);
         @(negedge clock);
      end else begin
         if (cmd == 2'h1) exp_cont = 1'b0;
         if (cmd == 2'h1 && hf) exp_func = fn;
         chk("conv_starts", 1, starts);
         chk("reading_valid", 1, reading.valid);
         chk("reading_value", 32'hA500_0000 + n_conv, reading.value);
         n_conv++;
         chk("init_ignored", exp_cont, ign);
         chk("trigger_restart", pc, rs);
         if (!exp_cont) chk("left_idle", 1, busy);
         if (!exp_cont) chk("idle_after", 1, idle);
         chk("continuous", exp_cont, cfg.continuous);
         chk("function", exp_func, cfg.func);
         chk("counts", 24'h010101, {cfg.arm_count, cfg.scan_count, cfg.meas_count});
      end
   endtask : run

   initial begin
      int i;
      void'($urandom(32'h90E4CD51));
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      @(negedge clock);
      chk("reset_idle", 1, idle);
      chk("reset_config", 29'h0000_0000 | 24'h010101, cfg);
      run(2'h0, 1'b0, 4'h0);
      set_cont(1'b1);
      run(2'h0, 1'b0, 4'h0);
      run(2'h0, 1'b0, 4'h0);
      run(2'h1, 1'b0, 4'h3);
      for (i = 0; i < 10; i++) begin
         set_cont(1'($urandom_range(1)));
         run(2'h1, 1'b1, 4'(i));
      end
      run(2'h1, 1'b1, 4'hC);
      for (i = 0; i < 40; i++) begin
         if ($urandom_range(3) == 0) set_cont(1'($urandom_range(1)));
         run(2'($urandom_range(1)), 1'($urandom_range(1)), 4'($urandom_range(9)));
      end
      results();
   end
endmodule : measure_read_sequencer_tb_top
